// ===== hdl/mrm_pkg.sv
// mrm_pkg: shared constants and carrier types for the mii receive/management block
// assumes a 125 MHz system clock and an external 4-bit mii phy
package mrm_pkg;
  localparam int NIB_W      = 4;              // nibble width
  localparam int BYTE_W     = 8;
  localparam int FIFO_DEPTH = 16;             // receive byte buffer depth
  localparam int DIV_W      = 8;              // management clock divider width
  localparam int ADDR_W     = 5;              // phy and register address width
  localparam int MDATA_W    = 16;             // management data bits
  localparam int FRAME_BITS = 64;             // preamble 32 + header 14 + ta 2 + data 16
  localparam int TA_POS     = 46;             // first turnaround bit index
  localparam int DATA_POS   = 48;             // first data bit index
  localparam logic [31:0] PREAMBLE = 32'hffff_ffff;
  localparam logic [1:0]  SOF      = 2'h1;
  localparam logic [1:0]  OP_RD    = 2'h2;
  localparam logic [1:0]  OP_WR    = 2'h1;
  localparam logic [1:0]  TA_WR    = 2'h2;
  localparam logic [1:0]  TA_RD    = 2'h3;    // line released, value unused
  localparam logic [6:0]  CNT_LAST = 7'h3f;   // last bit index of a frame

  typedef enum logic {MRM_IDLE = 1'b0, MRM_SHIFT = 1'b1} mrm_mstate_e;

  typedef struct packed {
    logic              err;                   // frame seen in error so far
    logic [BYTE_W-1:0] data;
  } mrm_rxword_s;

  typedef struct packed {
    logic               write;
    logic [ADDR_W-1:0]  phy;
    logic [ADDR_W-1:0]  reg_addr;
    logic [MDATA_W-1:0] wdata;
  } mrm_mcmd_s;
endpackage : mrm_pkg

// ===== hdl/mii_rx_mdio.sv
// mii_rx_mdio: mii receive path, transmit handshake, management master, receive fifo
// assumes every input is synchronous to clk except carrier sense and collision;
// the phy mii clocks are sampled as plain inputs and edge-detected.
`timescale 1ns/1ps

module mrm_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]       mem_ff [D];
  logic [AW-1:0]      wr_ff;
  logic [AW-1:0]      rd_ff;
  logic [$clog2(D+1)-1:0] cnt_ff;
  logic               push;
  logic               load;

  // the output stage counts as one of the D words, so at most D are ever held
  assign in_ready = ((cnt_ff + {{($clog2(D+1)-1){1'b0}}, out_valid}) != D[$clog2(D+1)-1:0]);
  assign push     = in_valid & in_ready;
  // registered output stage keeps out_data straight from a flop
  assign load     = (cnt_ff != '0) & (~out_valid | out_ready);

  always_ff @(posedge clk) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
      if (load) rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + {{($clog2(D+1)-1){1'b0}}, push} - {{($clog2(D+1)-1){1'b0}}, load};
    end
  end

  // output stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem_ff[rd_ff];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : mrm_fifo

module mii_rx_mdio
  import mrm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              full_duplex,
  input  wire logic              carrier_sense_in,
  input  wire logic              collision_in,
  output logic                   carrier_sensed,
  input  wire logic              rx_nibble_clock,
  input  wire logic              rx_data_valid,
  input  wire logic [NIB_W-1:0]  rx_nibble_data,
  input  wire logic              rx_error_flag,
  output mrm_rxword_s            rx_byte,
  output logic                   rx_byte_valid,
  input  wire logic              rx_byte_ready,
  output logic                   rx_frame_end,
  output logic                   rx_frame_bad,
  input  wire logic              tx_nibble_clock,
  input  wire logic [NIB_W-1:0]  tx_in_nibble,
  input  wire logic              tx_in_valid,
  input  wire logic              tx_in_last,
  output logic                   tx_in_take,
  output logic                   tx_data_enable,
  output logic [NIB_W-1:0]       tx_nibble_out,
  input  wire logic [DIV_W-1:0]  mgmt_clock_divider,
  input  wire mrm_mcmd_s         mgmt_cmd,
  input  wire logic              mgmt_start,
  output logic                   mgmt_busy,
  output logic                   mgmt_done,
  output logic [MDATA_W-1:0]     mgmt_rdata,
  output logic                   mgmt_clock_out,
  input  wire logic              mgmt_data_in,
  output logic                   mgmt_data_out,
  output logic                   mgmt_data_oe_n
);
  logic crs_meta_ff, col_meta_ff, col_ff;
  logic rxc_ff, txc_ff, rx_rise, tx_rise;
  logic [NIB_W-1:0] lo_ff;
  logic half_ff, err_ff, ovf_ff, in_frame_ff, push_ff, fifo_in_ready;
  mrm_rxword_s word_ff;
  logic tx_active_ff, tx_block;
  mrm_mstate_e mstate_ff;
  logic [DIV_W-1:0] div_ff;
  logic [6:0] bit_ff;
  logic [FRAME_BITS-1:0] sr_ff;
  logic rd_ff, tick;

  // two-flop synchronisers; the async pins wander against both mii clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crs_meta_ff    <= 1'b0;
      carrier_sensed <= 1'b0;
      col_meta_ff    <= 1'b0;
      col_ff         <= 1'b0;
    end else begin
      crs_meta_ff    <= carrier_sense_in;
      carrier_sensed <= crs_meta_ff;
      col_meta_ff    <= collision_in;
      col_ff         <= col_meta_ff;
    end
  end

  // mii clock edge detection, both phy clocks assumed free-running
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // start high: a clock already high at release must not look like a rise
      rxc_ff <= 1'b1;
      txc_ff <= 1'b1;
    end else begin
      rxc_ff <= rx_nibble_clock;
      txc_ff <= tx_nibble_clock;
    end
  end
  assign rx_rise = rx_nibble_clock & ~rxc_ff;
  assign tx_rise = tx_nibble_clock & ~txc_ff;

  // receive nibble pairing and frame status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lo_ff <= '0; half_ff <= 1'b0; err_ff <= 1'b0; in_frame_ff <= 1'b0;
      push_ff <= 1'b0; word_ff <= '0; rx_frame_end <= 1'b0; rx_frame_bad <= 1'b0;
    end else begin
      push_ff      <= 1'b0;
      rx_frame_end <= 1'b0;
      if (rx_rise) begin
        in_frame_ff <= rx_data_valid;
        if (rx_data_valid) begin
          if (rx_error_flag) err_ff <= 1'b1;
          if (!half_ff) begin
            lo_ff   <= rx_nibble_data;
            half_ff <= 1'b1;
          end else begin
            half_ff <= 1'b0;
            push_ff <= 1'b1;
            word_ff <= '{err: err_ff | rx_error_flag, data: {rx_nibble_data, lo_ff}};
          end
        end else if (in_frame_ff) begin
          // a stray odd nibble or a dropped byte also spoils the frame
          rx_frame_end <= 1'b1;
          rx_frame_bad <= err_ff | half_ff | ovf_ff;
          err_ff       <= 1'b0;
          half_ff      <= 1'b0;
        end
      end
    end
  end

  // overflow: the phy cannot be stalled, so a full buffer drops the byte; set wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) ovf_ff <= 1'b0;
    else if (push_ff && !fifo_in_ready) ovf_ff <= 1'b1;
    else if (rx_rise && !rx_data_valid && in_frame_ff) ovf_ff <= 1'b0;
  end

  mrm_fifo #(.W($bits(mrm_rxword_s)), .D(DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_ff),
    .in_data   (word_ff),
    .in_ready  (fifo_in_ready),
    .out_valid (rx_byte_valid),
    .out_data  (rx_byte),
    .out_ready (rx_byte_ready)
  );

  // transmit: defer on collision (full duplex) or carrier (half duplex) at start only
  assign tx_block = full_duplex ? col_ff : carrier_sensed;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_active_ff <= 1'b0; tx_data_enable <= 1'b0; tx_nibble_out <= '0; tx_in_take <= 1'b0;
    end else begin
      tx_in_take <= 1'b0;
      if (tx_rise) begin
        if (tx_in_valid && (tx_active_ff || !tx_block)) begin
          tx_data_enable <= 1'b1;
          tx_nibble_out  <= tx_in_nibble;
          tx_in_take     <= 1'b1;
          tx_active_ff   <= ~tx_in_last;
        end else begin
          tx_data_enable <= 1'b0;
          tx_active_ff   <= 1'b0;
        end
      end
    end
  end

  // management divider: one tick per half period of the management clock
  assign tick = (div_ff == '0);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) div_ff <= '0;
    else if (mstate_ff == MRM_IDLE || tick) div_ff <= mgmt_clock_divider;
    else div_ff <= div_ff - 1'b1;
  end

  // management frame engine: shift on falling edge, sample on rising edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mstate_ff <= MRM_IDLE; bit_ff <= '0; sr_ff <= '0; rd_ff <= 1'b0;
      mgmt_busy <= 1'b0; mgmt_done <= 1'b0; mgmt_rdata <= '0;
      mgmt_clock_out <= 1'b0; mgmt_data_out <= 1'b1; mgmt_data_oe_n <= 1'b1;
    end else begin
      mgmt_done <= 1'b0;
      case (mstate_ff)
        MRM_IDLE: begin
          mgmt_data_oe_n <= 1'b1;
          if (mgmt_start) begin
            sr_ff <= {PREAMBLE, SOF, mgmt_cmd.write ? OP_WR : OP_RD, mgmt_cmd.phy,
                      mgmt_cmd.reg_addr, mgmt_cmd.write ? TA_WR : TA_RD,
                      mgmt_cmd.write ? mgmt_cmd.wdata : 16'h0000};
            rd_ff          <= ~mgmt_cmd.write;
            bit_ff         <= '0;
            mstate_ff      <= MRM_SHIFT;
            mgmt_busy      <= 1'b1;
            mgmt_data_out  <= PREAMBLE[31];
            mgmt_data_oe_n <= 1'b0;
          end
        end
        MRM_SHIFT: begin
          if (tick) begin
            mgmt_clock_out <= ~mgmt_clock_out;
            if (!mgmt_clock_out) begin
              if (rd_ff && bit_ff >= 7'(DATA_POS))
                mgmt_rdata <= {mgmt_rdata[MDATA_W-2:0], mgmt_data_in};
            end else if (bit_ff == CNT_LAST) begin
              mstate_ff      <= MRM_IDLE;
              mgmt_busy      <= 1'b0;
              mgmt_done      <= 1'b1;
              mgmt_data_oe_n <= 1'b1;
            end else begin
              bit_ff         <= bit_ff + 1'b1;
              sr_ff          <= {sr_ff[FRAME_BITS-2:0], 1'b0};
              mgmt_data_out  <= sr_ff[FRAME_BITS-2];
              // release from turnaround on for reads only
              mgmt_data_oe_n <= rd_ff && (bit_ff + 1'b1 >= 7'(TA_POS));
            end
          end
        end
        default: mstate_ff <= MRM_IDLE;
      endcase
    end
  end

  // checks
  sequence s_rd_start;
    mstate_ff == MRM_IDLE && mgmt_start && !mgmt_cmd.write;
  endsequence
  property p_crs_sync;
    @(posedge clk) disable iff (sys_rst) ##2 (carrier_sensed == $past(carrier_sense_in, 2));
  endproperty
  a_crs_sync: assert property (p_crs_sync) else $error("carrier sync lag wrong");
  property p_rx_ignore;
    @(posedge clk) disable iff (sys_rst) rx_rise && !rx_data_valid |=> !push_ff;
  endproperty
  a_rx_ignore: assert property (p_rx_ignore) else $error("byte pushed without valid");
  property p_rx_pair;
    @(posedge clk) disable iff (sys_rst) rx_rise && rx_data_valid && half_ff
      |=> push_ff && word_ff.data == {$past(rx_nibble_data), $past(lo_ff)};
  endproperty
  a_rx_pair: assert property (p_rx_pair) else $error("byte order wrong");
  property p_rx_err;
    @(posedge clk) disable iff (sys_rst) rx_rise && rx_data_valid && rx_error_flag |=> err_ff;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("receive error lost");
  property p_err_gate;
    @(posedge clk) disable iff (sys_rst) rx_rise && !rx_data_valid |=> !err_ff;
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error taken without valid");
  property p_mdc_div;
    @(posedge clk) disable iff (sys_rst) mgmt_busy && !tick |=> $stable(mgmt_clock_out);
  endproperty
  a_mdc_div: assert property (p_mdc_div) else $error("mdc moved off tick");
  property p_rd_drive;
    @(posedge clk) disable iff (sys_rst) s_rd_start |=> !mgmt_data_oe_n && mgmt_data_out;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("preamble not driven");
  property p_wr_drive;
    @(posedge clk) disable iff (sys_rst) mgmt_busy && !rd_ff |-> !mgmt_data_oe_n;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write released line");
  property p_done;
    @(posedge clk) disable iff (sys_rst) mgmt_done |-> $past(bit_ff) == CNT_LAST;
  endproperty
  a_done: assert property (p_done) else $error("frame length wrong");
  property p_col;
    @(posedge clk) disable iff (sys_rst)
      tx_rise && !tx_active_ff && full_duplex && col_ff |=> !tx_data_enable;
  endproperty
  a_col: assert property (p_col) else $error("frame started under collision");
  property p_txen;
    @(posedge clk) disable iff (sys_rst) $changed(tx_data_enable) |-> $past(tx_rise);
  endproperty
  a_txen: assert property (p_txen) else $error("enable moved off tx edge");
endmodule : mii_rx_mdio

// ===== sim/mrm_phy.sv
// mrm_phy: behavioural phy on the far side of the mii receive and management ports
// assumes the bench calls its tasks; the management line has a pull-up
`timescale 1ns/1ps
module mrm_phy (
  input  wire logic  clk,
  input  wire logic  mgmt_clock_out,
  input  wire logic  mgmt_data_out,
  input  wire logic  mgmt_data_oe_n,
  output logic       mgmt_data_in,
  output logic       rx_nibble_clock,
  output logic       tx_nibble_clock,
  output logic       rx_data_valid,
  output logic [3:0] rx_nibble_data,
  output logic       rx_error_flag,
  output logic       carrier_sense_in,
  output logic       collision_in
);
  logic [63:0] sh = 64'h0;
  logic [6:0]  cnt = 7'h0;
  logic        rd = 1'b0;
  logic        p_oe = 1'b0;
  logic        p_d = 1'b1;
  logic [15:0] rdv = 16'h0;
  // free-running mii clocks, well below clk/2 since the mac samples them
  initial begin
    {rx_nibble_clock, tx_nibble_clock, rx_data_valid, rx_error_flag} = 4'h0;
    {carrier_sense_in, collision_in, rx_nibble_data} = 6'h0;
  end
  always #40 rx_nibble_clock = ~rx_nibble_clock;
  // half period a multiple of 8 ns keeps every edge off the rising edge of clk
  always #48 tx_nibble_clock = ~tx_nibble_clock;
  // released line floats to the pull-up level
  assign mgmt_data_in = !mgmt_data_oe_n ? mgmt_data_out : (p_oe ? p_d : 1'b1);
  // one nibble per receive clock, changed on its falling edge
  task automatic nib(input logic v, input logic [3:0] d, input logic e);
    @(negedge rx_nibble_clock);
    rx_data_valid = v;
    rx_nibble_data = v ? d : ~rx_nibble_data;
    rx_error_flag = e;
  endtask : nib
  // low nibble goes first
  task automatic send_byte(input logic [7:0] b, input logic e);
    nib(1'b1, b[3:0], e);
    nib(1'b1, b[7:4], 1'b0);
  endtask : send_byte
  // bench sets medium state; full duplex runs keep carrier low
  task automatic set_pins(input logic c, input logic k);
    @(negedge clk);
    carrier_sense_in = c;
    collision_in = k;
  endtask : set_pins
  task automatic arm(input logic [15:0] v);
    cnt = 7'h0;
    rd = 1'b0;
    rdv = v;
  endtask : arm
  // management slave: shift on the rising clock, answer reads on the falling one
  always @(posedge mgmt_clock_out) begin
    sh <= {sh[62:0], mgmt_data_in};
    cnt <= cnt + 7'h1;
    if (cnt == 7'h2f) rd <= (sh[12:11] == 2'h2);
  end
  always @(negedge mgmt_clock_out) begin
    p_oe = rd && cnt >= 7'h30 && cnt < 7'h40;
    p_d = p_oe ? rdv[7'h3f - cnt] : 1'b1;
  end
endmodule : mrm_phy

// ===== sim/testbench.sv
// testbench: self-checking bench for mii_rx_mdio with the mrm_phy model
// assumes a 125 MHz clk and inputs changed on its falling edge
`timescale 1ns/1ps
module testbench import mrm_pkg::*; ;
  logic clk, sys_rst, full_duplex, rx_byte_ready, tx_in_valid, tx_in_last, mgmt_start;
  logic carrier_sense_in, collision_in, carrier_sensed, rx_nibble_clock, rx_data_valid;
  logic rx_error_flag, rx_byte_valid, rx_frame_end, rx_frame_bad, tx_nibble_clock;
  logic tx_in_take, tx_data_enable, mgmt_busy, mgmt_done, mgmt_clock_out;
  logic mgmt_data_in, mgmt_data_out, mgmt_data_oe_n;
  logic [NIB_W-1:0] rx_nibble_data, tx_in_nibble, tx_nibble_out;
  logic [DIV_W-1:0] mgmt_clock_divider;
  logic [MDATA_W-1:0] mgmt_rdata;
  mrm_rxword_s rx_byte;
  mrm_mcmd_s mgmt_cmd;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int ends = 0;
  int hi = 0;
  mii_rx_mdio mii_rx_mdio_i (.clk, .sys_rst, .full_duplex, .carrier_sense_in, .collision_in,
    .carrier_sensed, .rx_nibble_clock, .rx_data_valid, .rx_nibble_data, .rx_error_flag,
    .rx_byte, .rx_byte_valid, .rx_byte_ready, .rx_frame_end, .rx_frame_bad,
    .tx_nibble_clock, .tx_in_nibble, .tx_in_valid, .tx_in_last, .tx_in_take,
    .tx_data_enable, .tx_nibble_out, .mgmt_clock_divider, .mgmt_cmd, .mgmt_start,
    .mgmt_busy, .mgmt_done, .mgmt_rdata, .mgmt_clock_out, .mgmt_data_in, .mgmt_data_out,
    .mgmt_data_oe_n);
  mrm_phy mrm_phy_i (.clk, .mgmt_clock_out, .mgmt_data_out, .mgmt_data_oe_n, .mgmt_data_in,
    .rx_nibble_clock, .tx_nibble_clock, .rx_data_valid, .rx_nibble_data, .rx_error_flag,
    .carrier_sense_in, .collision_in);
  task automatic close_out;
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cycle ceiling, frame-end count and management clock high time
  always @(posedge clk) begin
    cycles++;
    if (rx_frame_end === 1'b1) ends++;
    if (mgmt_busy === 1'b1 && mgmt_clock_out === 1'b1) hi++;
    if (cycles == 30000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic wait_ends(input int n);
    for (int i = 0; i < 2000 && ends < n; i++) @(negedge clk);
    chk("rx_frame_end", 1, ends >= n);
  endtask : wait_ends
  // one byte out of the buffer, taken by a one-cycle ready
  task automatic take(input logic [7:0] e, input logic er);
    for (int i = 0; i < 50 && rx_byte_valid !== 1'b1; i++) @(negedge clk);
    chk("rx_byte", {er, e}, rx_byte);
    rx_byte_ready = 1'b1;
    @(negedge clk);
    rx_byte_ready = 1'b0;
    @(negedge clk);
  endtask : take
  task automatic t_crs;
    mrm_phy_i.set_pins(1'b1, 1'b0);
    @(negedge clk);
    chk("carrier_sensed", 0, carrier_sensed);
    @(negedge clk);
    chk("carrier_sensed", 1, carrier_sensed);
    mrm_phy_i.set_pins(1'b0, 1'b0);
  endtask : t_crs
  // error marks and noise while data valid is low must not touch the frame
  task automatic t_rx_good;
    mrm_phy_i.nib(1'b0, 4'h0, 1'b1);
    mrm_phy_i.send_byte(8'ha5, 1'b0);
    mrm_phy_i.send_byte(8'h3c, 1'b0);
    mrm_phy_i.send_byte(8'h0f, 1'b0);
    mrm_phy_i.nib(1'b0, 4'h0, 1'b1);
    wait_ends(1);
    chk("rx_frame_bad", 0, rx_frame_bad);
    take(8'ha5, 1'b0);
    take(8'h3c, 1'b0);
    take(8'h0f, 1'b0);
  endtask : t_rx_good
  task automatic t_rx_err;
    mrm_phy_i.send_byte(8'h11, 1'b0);
    mrm_phy_i.send_byte(8'h22, 1'b1);
    mrm_phy_i.nib(1'b0, 4'h0, 1'b0);
    wait_ends(2);
    chk("rx_frame_bad", 1, rx_frame_bad);
    take(8'h11, 1'b0);
    take(8'h22, 1'b1);
  endtask : t_rx_err
  // eighteen bytes into a sixteen-word buffer with the reader stalled
  task automatic t_rx_ovf;
    for (int i = 0; i < 18; i++) mrm_phy_i.send_byte(8'(i), 1'b0);
    mrm_phy_i.nib(1'b0, 4'h0, 1'b0);
    wait_ends(3);
    chk("rx_frame_bad", 1, rx_frame_bad);
    for (int i = 0; i < 16; i++) take(8'(i), 1'b0);
    chk("rx_byte_valid", 0, rx_byte_valid);
  endtask : t_rx_ovf
  // a trailing odd nibble is dropped and spoils the frame
  task automatic t_rx_odd;
    mrm_phy_i.send_byte(8'h7e, 1'b0);
    mrm_phy_i.nib(1'b1, 4'h3, 1'b0);
    mrm_phy_i.nib(1'b0, 4'h0, 1'b0);
    wait_ends(4);
    chk("rx_frame_bad", 1, rx_frame_bad);
    take(8'h7e, 1'b0);
    chk("rx_byte_valid", 0, rx_byte_valid);
  endtask : t_rx_odd
  task automatic t_mgmt(input logic w, input logic [15:0] v, input logic [7:0] d);
    logic [63:0] exp;
    mrm_phy_i.arm(v);
    mgmt_cmd = '{write: w, phy: 5'h13, reg_addr: 5'h0a, wdata: v};
    mgmt_clock_divider = d;
    hi = 0;
    mgmt_start = 1'b1;
    @(negedge clk);
    mgmt_start = 1'b0;
    chk("mgmt_busy", 1, mgmt_busy);
    // a second start while busy must be ignored
    @(negedge clk);
    mgmt_start = 1'b1;
    @(negedge clk);
    mgmt_start = 1'b0;
    for (int i = 0; i < 3000 && mgmt_done !== 1'b1; i++) @(negedge clk);
    chk("mgmt_done", 1, mgmt_done);
    chk("mgmt_busy", 0, mgmt_busy);
    exp = {32'hffff_ffff, 2'h1, w ? 2'h1 : 2'h2, 5'h13, 5'h0a, 2'h2, v};
    chk("mgmt_header", exp[63:18], mrm_phy_i.sh[63:18]);
    if (w) chk("mgmt_frame", exp, mrm_phy_i.sh);
    else chk("mgmt_rdata", v, mgmt_rdata);
    chk("mgmt_clock_high", 64 * (d + 1), hi);
    @(negedge clk);
  endtask : t_mgmt
  task automatic wait_take;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (tx_in_take === 1'b1) break;
    end
    chk("tx_in_take", 1, tx_in_take);
  endtask : wait_take
  // two-nibble frame, then a full-duplex collision holding off the next one
  task automatic t_tx;
    int takes;
    takes = 0;
    {tx_in_nibble, tx_in_valid, tx_in_last} = {4'h6, 2'h2};
    wait_take();
    chk("tx_enable", {1'b1, 4'h6}, {tx_data_enable, tx_nibble_out});
    {tx_in_nibble, tx_in_last} = {4'h9, 1'b1};
    wait_take();
    chk("tx_enable", {1'b1, 4'h9}, {tx_data_enable, tx_nibble_out});
    tx_in_valid = 1'b0;
    for (int i = 0; i < 30 && tx_data_enable !== 1'b0; i++) @(negedge clk);
    chk("tx_enable", 0, tx_data_enable);
    full_duplex = 1'b1;
    mrm_phy_i.set_pins(1'b0, 1'b1);
    {tx_in_nibble, tx_in_valid} = {4'h2, 1'b1};
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      takes += int'(tx_in_take === 1'b1);
    end
    chk("blocked_takes", 0, takes);
    mrm_phy_i.set_pins(1'b0, 1'b0);
    wait_take();
    chk("tx_enable", {1'b1, 4'h2}, {tx_data_enable, tx_nibble_out});
    tx_in_valid = 1'b0;
  endtask : t_tx
  initial begin
    sys_rst = 1'b1;
    {full_duplex, rx_byte_ready, tx_in_valid, tx_in_last, mgmt_start} = 5'h0;
    tx_in_nibble = 4'h0;
    mgmt_clock_divider = 8'h0;
    mgmt_cmd = '0;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_crs();
    t_rx_good();
    t_rx_err();
    t_rx_ovf();
    t_rx_odd();
    t_mgmt(1'b1, 16'h5a96, 8'h01);
    t_mgmt(1'b0, 16'hc3a5, 8'h02);
    t_tx();
    close_out();
  end
endmodule : testbench
